/* src/timer_defines.svh */
// Offsets, field positions and codes of the timer block.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
`define ADDR_CTRL0     3'h0
`define ADDR_CTRL1     3'h1
`define ADDR_COUNT_LO  3'h2
`define ADDR_COUNT_HI  3'h3
`define ADDR_COMPARE_A_VALUE_LO   3'h4
`define ADDR_COMPARE_A_VALUE_HI   3'h5
`define ADDR_COMPARE_P_VALUE      3'h6
`define ADDR_FLAGS     3'h7
`define CTRL0_ON_BIT   3
`define CTRL0_TRIG_BIT 2
`define MODE_CAPTURE   2'h1
`define MODE_PWM       2'h2
`define PIN_INACTIVE   2'h0
`define PIN_ACTIVE     2'h1
`define PIN_PWM        2'h2
`define PIN_PULSE      2'h3
`define CAP_RISE       2'h0
`define CAP_FALL       2'h1
`define CAP_BOTH       2'h2
`define FULL_COUNT     11'h400
`define P_UNIT_BITS    7
`endif

/* src/timer_pkg.sv */
// Types for the timer block: the state records of each module.
// Assumes timer_defines.svh supplies all numeric constants.
package timer_pkg;
  typedef struct packed {
    logic [7:0] rdata;
    logic       on;
    logic       trig_en;
    logic [1:0] clk_sel;
    logic [1:0] mode;
    logic [1:0] pin_fn;
    logic       oc;
    logic       pol;
    logic       swap;
    logic       clr_sel;
    logic [9:0] cnt;
    logic [9:0] compare_a_value;
    logic [2:0] compare_p_value;
    logic       flag_a;
    logic       flag_p;
    logic       pin;
    logic       pin_oe_n;
  } timer_state_t;
  typedef struct packed {
    logic [2:0] s;
    logic       lvl;
    logic       rise;
    logic       fall;
  } sync_state_t;
  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } presc_state_t;
endpackage

/* src/edge_if.sv */
// Synchronised pin level and its one-cycle edge pulses.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, rise, fall);
  modport dst (input level, rise, fall);
endinterface
`default_nettype wire

/* src/pin_sync.sv */
// Three-stage pin synchroniser with edge pulses.
// Assumes an asynchronous pin; a change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import timer_pkg::*;
(
  input  wire logic clk_i,  // System clock
  input  wire logic srst_i, // Synchronous reset
  input  wire logic pin_i,  // Raw pin
  edge_if.src       e       // Clean level and edges
);
  sync_state_t q;
  sync_state_t d;
  always_comb begin
    d      = q;
    d.s    = {q.s[1:0], pin_i};
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (q.s[1] == q.s[2] && q.s[2] != q.lvl) begin
      d.lvl  = q.s[2];
      d.rise = q.s[2];
      d.fall = ~q.s[2];
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) q <= '0;
    else q <= d;
  end
  assign e.level = q.lvl;
  assign e.rise  = q.rise;
  assign e.fall  = q.fall;
endmodule // pin_sync
`default_nettype wire

/* src/clk_prescaler.sv */
// Count-enable divider: one-cycle tick every 1, 4, 16 or 64 clocks.
// Assumes the select is only changed while the counter is off.
`timescale 1ns/1ps
`default_nettype none
module clk_prescaler
  import timer_pkg::*;
(
  input  wire logic       clk_i,  // System clock
  input  wire logic       srst_i, // Synchronous reset
  input  wire logic [1:0] sel_i,  // Divide select
  output logic            tick_o  // Count enable pulse
);
  presc_state_t q;
  presc_state_t d;
  logic [5:0]   mask;
  always_comb begin
    case (sel_i)
      2'h0:    mask = 6'h00;
      2'h1:    mask = 6'h03;
      2'h2:    mask = 6'h0f;
      default: mask = 6'h3f;
    endcase
    d      = q;
    d.cnt  = q.cnt + 6'h01;
    d.tick = ((q.cnt & mask) == mask);
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) q <= '0;
    else q <= d;
  end
  assign tick_o = q.tick;
endmodule // clk_prescaler
`default_nettype wire

/* src/standard_timer.sv */
// Standard timer: PWM output, single pulse output and capture input modes.
// Assumes an 8-bit register port and asynchronous timer and trigger pins.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module standard_timer
  import timer_pkg::*;
(
  input  wire logic       clk_i,                // 50 MHz system clock
  input  wire logic       srst_i,               // Synchronous reset, high
  input  wire logic [2:0] addr_i,               // Register address
  input  wire logic [7:0] wdata_i,              // Write data
  input  wire logic       we_i,                 // Write strobe
  input  wire logic       re_i,                 // Read strobe
  output logic      [7:0] rdata_o,              // Read data, cycle after strobe
  input  wire logic       timer_io_i,           // Timer pin input level
  output logic            timer_io_o,           // Timer pin output level
  output logic            timer_io_oe_n_o,      // Timer pin drive enable, low
  input  wire logic       external_clock_pin_i, // External trigger pin
  output logic            compare_a_flag_o,     // Compare A flag
  output logic            compare_p_flag_o      // Compare P flag
);
  timer_state_t q;
  timer_state_t d;

  edge_if io_e ();
  edge_if ext_e ();
  logic tick;

  pin_sync u_io_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pin_i  (timer_io_i),
    .e      (io_e.src)
  );

  pin_sync u_ext_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pin_i  (external_clock_pin_i),
    .e      (ext_e.src)
  );

  clk_prescaler u_presc (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .sel_i  (q.clk_sel),
    .tick_o (tick)
  );

  logic        is_pwm;
  logic        is_sp;
  logic        is_cap;
  logic        run;
  logic        start;
  logic        cap_ev;
  logic        a_hit;
  logic        p_hit;
  logic        per_hit;
  logic [10:0] cnt_nx;
  logic [10:0] a_len;
  logic [10:0] p_len;
  logic [10:0] per_len;
  logic [10:0] duty_len;
  logic        wr_ctrl0;
  logic        wr_compare_a_value;

  // Both comparators count lengths, so a zero code stands for the full 1024
  assign p_len    = (q.compare_p_value == 3'h0) ? `FULL_COUNT
                                     : {1'b0, q.compare_p_value, {`P_UNIT_BITS{1'b0}}};
  assign a_len    = (q.compare_a_value == 10'h000) ? `FULL_COUNT : {1'b0, q.compare_a_value};
  assign cnt_nx   = {1'b0, q.cnt} + 11'h001;
  assign a_hit    = (cnt_nx == a_len);
  assign p_hit    = (cnt_nx == p_len);
  // Clear select is stored but never consulted here
  assign per_len  = q.swap ? a_len : p_len;
  assign duty_len = q.swap ? p_len : a_len;
  assign per_hit  = (cnt_nx == per_len);
  assign is_pwm   = (q.mode == `MODE_PWM) && (q.pin_fn != `PIN_PULSE);
  assign is_sp    = (q.mode == `MODE_PWM) && (q.pin_fn == `PIN_PULSE);
  assign is_cap   = (q.mode == `MODE_CAPTURE);
  assign run      = q.on && tick;
  assign wr_ctrl0 = we_i && (addr_i == `ADDR_CTRL0);
  assign wr_compare_a_value  = we_i && ((addr_i == `ADDR_COMPARE_A_VALUE_LO) || (addr_i == `ADDR_COMPARE_A_VALUE_HI));
  assign start    = d.on && !q.on;

  always_comb begin
    case (q.pin_fn)
      `CAP_RISE: cap_ev = io_e.rise;
      `CAP_FALL: cap_ev = io_e.fall;
      `CAP_BOTH: cap_ev = io_e.rise || io_e.fall;
      default:   cap_ev = 1'b0;
    endcase
  end

  always_comb begin
    d       = q;
    d.rdata = 8'h00;
    if (we_i) begin
      case (addr_i)
        `ADDR_CTRL0: begin
          d.on      = wdata_i[`CTRL0_ON_BIT];
          d.trig_en = wdata_i[`CTRL0_TRIG_BIT];
          d.clk_sel = wdata_i[1:0];
        end
        `ADDR_CTRL1: begin
          d.mode    = wdata_i[7:6];
          d.pin_fn  = wdata_i[5:4];
          d.oc      = wdata_i[3];
          d.pol     = wdata_i[2];
          d.swap    = wdata_i[1];
          d.clr_sel = wdata_i[0];
        end
        `ADDR_COMPARE_A_VALUE_LO: d.compare_a_value[7:0] = wdata_i;
        `ADDR_COMPARE_A_VALUE_HI: d.compare_a_value[9:8] = wdata_i[1:0];
        `ADDR_COMPARE_P_VALUE:    d.compare_p_value      = wdata_i[2:0];
        `ADDR_FLAGS: begin
          if (wdata_i[0]) d.flag_a = 1'b0;
          if (wdata_i[1]) d.flag_p = 1'b0;
        end
        default: ;
      endcase
    end
    // External trigger can only start a pulse, never retrigger a running one
    if (is_sp && q.trig_en && ext_e.rise && !q.on) d.on = 1'b1;
    if (is_sp && run && a_hit) d.on = 1'b0;

    // Counter: zeroed on counter-on rise, else stepped by the prescaler tick
    if (d.on && !q.on) begin
      d.cnt = 10'h000;
    end else if (run) begin
      if (is_sp) begin
        d.cnt = cnt_nx[9:0];
      end else if (is_pwm && per_hit) begin
        d.cnt = 10'h000;
      end else if (is_cap && p_hit) begin
        d.cnt = 10'h000;
      end else begin
        d.cnt = cnt_nx[9:0];
      end
    end

    // Hardware sets are applied after software clears so they win
    if (run && is_pwm && a_hit) d.flag_a = 1'b1;
    if (run && is_pwm && p_hit) d.flag_p = 1'b1;
    if (run && is_sp && a_hit) d.flag_a = 1'b1;
    if (run && is_cap && p_hit) d.flag_p = 1'b1;
    // Capture beats a software write to compare A in the same cycle
    if (is_cap && q.on && cap_ev) begin
      d.compare_a_value   = q.cnt;
      d.flag_a = 1'b1;
    end

    // Pin: level control picks the active level, invert flips it last
    d.pin_oe_n = 1'b1;
    if (is_pwm) begin
      d.pin_oe_n = 1'b0;
      case (q.pin_fn)
        `PIN_INACTIVE: d.pin = ~q.oc ^ q.pol;
        `PIN_ACTIVE:   d.pin = q.oc ^ q.pol;
        default: begin
          // Tested on d directly so this process never reads a net derived from itself
          if (d.on && !q.on) d.pin = q.oc ^ q.pol;
          else d.pin = (({1'b0, d.cnt} < duty_len) ? q.oc : ~q.oc) ^ q.pol;
        end
      endcase
    end else if (is_sp) begin
      d.pin_oe_n = 1'b0;
      d.pin      = (d.on ? q.oc : ~q.oc) ^ q.pol;
    end else begin
      // Capture and other modes leave the pin undriven
      d.pin = 1'b0;
    end

    if (re_i) begin
      case (addr_i)
        `ADDR_CTRL0:    d.rdata = {4'h0, q.on, q.trig_en, q.clk_sel};
        `ADDR_CTRL1:    d.rdata = {q.mode, q.pin_fn, q.oc, q.pol, q.swap, q.clr_sel};
        `ADDR_COUNT_LO: d.rdata = q.cnt[7:0];
        `ADDR_COUNT_HI: d.rdata = {6'h00, q.cnt[9:8]};
        `ADDR_COMPARE_A_VALUE_LO:  d.rdata = q.compare_a_value[7:0];
        `ADDR_COMPARE_A_VALUE_HI:  d.rdata = {6'h00, q.compare_a_value[9:8]};
        `ADDR_COMPARE_P_VALUE:     d.rdata = {5'h00, q.compare_p_value};
        `ADDR_FLAGS:    d.rdata = {6'h00, q.flag_p, q.flag_a};
        default:        d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q          <= '0;
      q.pin_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata_o          = q.rdata;
  assign timer_io_o       = q.pin;
  assign timer_io_oe_n_o  = q.pin_oe_n;
  assign compare_a_flag_o = q.flag_a;
  assign compare_p_flag_o = q.flag_p;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_sp_hit;
    is_sp && run && a_hit;
  endsequence

  sequence s_sp_end;
    !q.on && q.flag_a && (q.pin == (~q.oc ^ q.pol));
  endsequence

  sequence s_cap_hit;
    is_cap && q.on && cap_ev && !srst_i;
  endsequence

  property p_sp_pulse_end;
    s_sp_hit ##0 (!wr_ctrl0 && $stable(q.oc)) |=> s_sp_end;
  endproperty

  a_sp_trailing_edge: assert property (p_sp_pulse_end)
    else $error("single pulse did not end on compare A match");

  a_sp_flag_raise: assert property (s_sp_hit |=> q.flag_a)
    else $error("compare A flag missing in single pulse");

  a_sp_leading_edge: assert property (is_sp && start |=> q.cnt == 10'h000 && q.on
                                      && q.pin == (q.oc ^ q.pol))
    else $error("single pulse start did not zero counter or drive leading edge");

  a_pwm_period_clear: assert property (is_pwm && run && per_hit && !start
                                       |=> q.cnt == 10'h000)
    else $error("PWM period match did not clear counter");

  a_pwm_both_flags: assert property (is_pwm && run && a_hit && p_hit
                                     |=> q.flag_a && q.flag_p)
    else $error("PWM compare flags not both raised");

  a_pwm_full_duty: assert property (is_pwm && q.pin_fn == `PIN_PWM && q.on
                                    && duty_len >= per_len ##1 $stable({q.oc, q.pol})
                                    |-> q.pin == (q.oc ^ q.pol))
    else $error("PWM output left active level at full duty");

  a_pwm_forced_low: assert property (is_pwm && q.pin_fn == `PIN_INACTIVE
                                     ##1 $stable({q.oc, q.pol})
                                     |-> q.pin == (~q.oc ^ q.pol) && !q.pin_oe_n)
    else $error("forced inactive level not driven");

  a_cap_latch_count: assert property (s_cap_hit |=> q.compare_a_value == $past(q.cnt) && q.flag_a)
    else $error("capture did not latch counter");

  a_cap_disabled: assert property (is_cap && q.pin_fn == `PIN_PULSE && !wr_compare_a_value
                                   |=> $stable(q.compare_a_value))
    else $error("capture happened while disabled");

  a_cap_p_clear: assert property (is_cap && run && p_hit && !start
                                  |=> q.cnt == 10'h000 && q.flag_p)
    else $error("capture mode compare P did not clear counter");

  a_cap_free_run: assert property (is_cap && run && !p_hit && !wr_ctrl0
                                   |=> q.cnt == $past(cnt_nx[9:0]))
    else $error("capture counter did not advance");

  a_cap_no_output: assert property (is_cap ##1 is_cap |-> q.pin_oe_n)
    else $error("pin driven in capture mode");

endmodule // standard_timer
`default_nettype wire

/* bench/pin_partner.sv */
// Far side of the timer: the shared timer pin and the external trigger pin.
// Assumes the bench sets the levels; the timer pin has a pull-up when released.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic cap_en_i,  // Partner drives the timer pin
  input  wire logic cap_lvl_i, // Level driven on the timer pin
  input  wire logic trig_i,    // Level driven on the trigger pin
  input  wire logic pin_o_i,   // Timer pin output level
  input  wire logic pin_oe_n_i,// Timer pin drive enable, low
  output logic      line_o,    // Resolved timer pin level
  output logic      ext_o      // Trigger pin level
);
  // The timer wins while it drives; otherwise the partner or the pull-up
  assign line_o = !pin_oe_n_i ? pin_o_i : (cap_en_i ? cap_lvl_i : 1'b1);
  assign ext_o  = trig_i;
endmodule // pin_partner
`default_nettype wire

/* bench/timer_pwm_pulse_capture_modes_test.sv */
// Self-checking bench for the standard timer in PWM, single pulse and capture modes.
// Assumes the register map of timer_defines.svh and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module timer_pwm_pulse_capture_modes_test;
  import timer_pkg::*;
  logic       clk_i, srst_i, we_i, re_i, cap_en, cap_lvl, trig, rd_pend;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic       line, ext, io_o, io_oe_n, flag_a, flag_p, oc, pol, act;
  logic [7:0] expq[$];
  int         miscompares, n_checks, w, duty;
  int         per[5], exp_act[5];
  logic [9:0] compare_a_value_v[5];
  logic [2:0] compare_p_value_v[5];
  logic [1:0] fn_v[5];
  logic       swap_v[5];

  standard_timer standard_timer_inst (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .timer_io_i(line),
    .timer_io_o(io_o), .timer_io_oe_n_o(io_oe_n), .external_clock_pin_i(ext),
    .compare_a_flag_o(flag_a), .compare_p_flag_o(flag_p));
  pin_partner pin_partner_inst (.cap_en_i(cap_en), .cap_lvl_i(cap_lvl), .trig_i(trig),
    .pin_o_i(io_o), .pin_oe_n_i(io_oe_n), .line_o(line), .ext_o(ext));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i    <= 1'b0;
  endtask

  // Expected value is noted first; the monitor pairs it with the answer
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    expq.push_back(exp);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i   <= 1'b0;
  endtask

  // Counts cycles at the given level, sampled just after each edge
  task automatic measure(input int n, input logic lvl, output int cnt);
    cnt = 0;
    repeat (n) begin
      #1;
      if (io_o === lvl) cnt++;
      @(posedge clk_i);
    end
  endtask

  task automatic stop_clear();
    wr(`ADDR_CTRL0, 8'h00);
    wr(`ADDR_FLAGS, 8'h03);
  endtask

  always @(posedge clk_i) begin
    if (rd_pend) check(rdata_o, expq.pop_front());
    rd_pend <= re_i;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    final_report();
  end

  initial begin
    srst_i = 1'b1; we_i = 1'b0; re_i = 1'b0; addr_i = 3'h0; wdata_i = 8'h00;
    cap_en = 1'b1; cap_lvl = 1'b0; trig = 1'b0; rd_pend = 1'b0;
    w = $urandom(32'h61dbfe03);
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    check(io_oe_n, 1'b1);
    wr(`ADDR_COMPARE_A_VALUE_HI, 8'hff);
    rd(`ADDR_COMPARE_A_VALUE_HI, 8'h03);
    // PWM: plain duty, swapped sources, full duty, forced inactive and active
    duty = 1 + $urandom % 127;
    per = '{128, 200, 128, 128, 128};
    exp_act = '{duty, 128, 128, 0, 128};
    compare_a_value_v = '{duty[9:0], 10'd200, 10'd300, duty[9:0], duty[9:0]};
    compare_p_value_v = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
    fn_v = '{2'h2, 2'h2, 2'h2, 2'h0, 2'h1};
    swap_v = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int c = 0; c < 5; c++) begin
      oc = $urandom;
      pol = $urandom;
      stop_clear();
      wr(`ADDR_COMPARE_A_VALUE_LO, compare_a_value_v[c][7:0]);
      wr(`ADDR_COMPARE_A_VALUE_HI, {6'h00, compare_a_value_v[c][9:8]});
      wr(`ADDR_COMPARE_P_VALUE, {5'h00, compare_p_value_v[c]});
      wr(`ADDR_CTRL1, {2'h2, fn_v[c], oc, pol, swap_v[c], 1'($urandom)});
      wr(`ADDR_CTRL0, 8'h08);
      repeat (450) @(posedge clk_i);
      measure(per[c], oc ^ pol, w);
      check(w, exp_act[c]);
      check(io_oe_n, 1'b0);
      rd(`ADDR_FLAGS, (c == 2) ? 8'h02 : 8'h03);
    end
    // Single pulse, software start, width set by compare A
    duty = 20 + $urandom % 40;
    oc = $urandom;
    pol = $urandom;
    act = oc ^ pol;
    stop_clear();
    wr(`ADDR_COMPARE_A_VALUE_LO, duty[7:0]);
    wr(`ADDR_COMPARE_A_VALUE_HI, 8'h00);
    wr(`ADDR_COMPARE_P_VALUE, 8'($urandom % 8));
    wr(`ADDR_CTRL1, {2'h2, 2'h3, oc, pol, 2'($urandom)});
    wr(`ADDR_CTRL0, 8'h08);
    measure(150, act, w);
    check(w >= duty && w <= duty + 1, 1'b1);
    rd(`ADDR_CTRL0, 8'h00);
    rd(`ADDR_FLAGS, 8'h01);
    // Single pulse started from the trigger pin, ended by software
    wr(`ADDR_FLAGS, 8'h03);
    wr(`ADDR_COMPARE_A_VALUE_LO, 8'hf4);
    wr(`ADDR_COMPARE_A_VALUE_HI, 8'h01);
    wr(`ADDR_CTRL0, 8'h04);
    trig <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(`ADDR_CTRL0, 8'h0c);
    check(io_o, act);
    trig <= 1'b0;
    wr(`ADDR_CTRL0, 8'h00);
    repeat (2) @(posedge clk_i);
    check(io_o, 1'(~act));
    // Capture on every edge selection
    for (int k = 0; k < 4; k++) begin
      stop_clear();
      wr(`ADDR_CTRL1, {2'h1, 2'(k), 4'($urandom)});
      wr(`ADDR_COMPARE_P_VALUE, 8'h00);
      wr(`ADDR_COMPARE_A_VALUE_HI, 8'h03);
      cap_lvl <= 1'b0;
      wr(`ADDR_CTRL0, 8'h08);
      repeat (10) @(posedge clk_i);
      check(io_oe_n, 1'b1);
      cap_lvl <= 1'b1;
      repeat (10) @(posedge clk_i);
      rd(`ADDR_FLAGS, (k == 0 || k == 2) ? 8'h01 : 8'h00);
      rd(`ADDR_COMPARE_A_VALUE_HI, (k == 0 || k == 2) ? 8'h00 : 8'h03);
      wr(`ADDR_FLAGS, 8'h03);
      wr(`ADDR_COMPARE_A_VALUE_HI, 8'h03);
      cap_lvl <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(`ADDR_FLAGS, (k == 1 || k == 2) ? 8'h01 : 8'h00);
      rd(`ADDR_COMPARE_A_VALUE_HI, (k == 1 || k == 2) ? 8'h00 : 8'h03);
    end
    // Compare P wraps the capture counter while pin activity is ignored
    stop_clear();
    wr(`ADDR_COMPARE_P_VALUE, 8'h01);
    wr(`ADDR_CTRL0, 8'h08);
    repeat (14) begin
      cap_lvl <= ~cap_lvl;
      repeat (10) @(posedge clk_i);
    end
    rd(`ADDR_FLAGS, 8'h02);
    rd(`ADDR_COUNT_HI, 8'h00);
    repeat (3) @(posedge clk_i);
    final_report();
  end
endmodule // timer_pwm_pulse_capture_modes_test
`default_nettype wire
